// File: design/dpr_host_pkg.sv
// constants, register map and timing for the dual-port memory port controller
package dpr_host_pkg;

  // memory port shape
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam logic [9:0] MBOX_LEFT_ADDR = 10'h3fe;
  localparam logic [9:0] MBOX_RIGHT_ADDR = 10'h3ff;

  // software register bus shape
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;

  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_STALL_BIT = 2;
  localparam int STAT_CONT_BIT = 3;
  localparam int STAT_MBOX_BIT = 4;

  // values after reset
  localparam logic [9:0] ADDR_RESET = 10'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // clock and pin timing, clock period in ps, pin times in ns
  localparam int CLK_PERIOD_PS = 25000;
  localparam int FLAG_ACCESS_NS = 20;
  localparam int WRITE_TO_FLAG_GAP_NS = 0;
  localparam int WRITE_PULSE_NS = 30;
  localparam int WRITE_HOLD_AFTER_RELEASE_NS = 20;
  localparam int READ_ACCESS_NS = 35;
  localparam int RELEASE_TO_DATA_DELAY_NS = 35;

  // least time in ns rounded up to whole cycles, never under one
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  localparam int FLAG_CYC = min_cycles(FLAG_ACCESS_NS + WRITE_TO_FLAG_GAP_NS);
  localparam int WPULSE_CYC = min_cycles(WRITE_PULSE_NS);
  localparam int HOLD_CYC = min_cycles(WRITE_HOLD_AFTER_RELEASE_NS);
  localparam int READ_CYC = min_cycles(READ_ACCESS_NS);
  localparam int RELEASE_CYC = min_cycles(RELEASE_TO_DATA_DELAY_NS);

  // word decode of a bus address against a register offset
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction : reg_hit

endpackage : dpr_host_pkg

// File: design/dpr_axil_port.sv
// axi4-lite slave front end: one write and one read at a time, hands out register strobes
module dpr_axil_port (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // write address and data channels
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [dpr_host_pkg::AXI_AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [dpr_host_pkg::AXI_DW-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // write response channel
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // read channels
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [dpr_host_pkg::AXI_AW-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [dpr_host_pkg::AXI_DW-1:0] o_rdata,
  output logic [1:0] o_rresp,
  // register side
  output logic o_wr_en,
  output logic [dpr_host_pkg::AXI_AW-1:0] o_wr_addr,
  output logic [dpr_host_pkg::AXI_DW-1:0] o_wr_data,
  output logic [3:0] o_wr_strb,
  output logic [dpr_host_pkg::AXI_AW-1:0] o_rd_addr,
  input wire logic [dpr_host_pkg::AXI_DW-1:0] i_rd_data
);
  import dpr_host_pkg::*;

  logic aw_full_q;
  logic w_full_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [AXI_DW-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [AXI_DW-1:0] rdata_q;
  wire aw_take;
  wire w_take;
  wire ar_take;

  // channels are held until both halves of a write are present; no new write until bresp is taken
  assign o_awready = !aw_full_q && !bvalid_q;
  assign o_wready = !w_full_q && !bvalid_q;
  assign aw_take = i_awvalid && o_awready;
  assign w_take = i_wvalid && o_wready;
  assign o_wr_en = aw_full_q && w_full_q && !bvalid_q;
  assign o_wr_addr = aw_addr_q;
  assign o_wr_data = w_data_q;
  assign o_wr_strb = w_strb_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = RESP_OKAY;

  // read data is sampled when the address is taken, so it reflects that cycle's state
  assign o_arready = !rvalid_q;
  assign ar_take = i_arvalid && o_arready;
  assign o_rd_addr = i_araddr;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = RESP_OKAY;

  // write path holding registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end else if (o_wr_en) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end else if (o_wr_en) begin
        w_full_q <= 1'b0;
      end
      if (o_wr_en) begin
        bvalid_q <= 1'b1;
      end else if (i_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read path
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= i_rd_data;
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : dpr_axil_port

// File: design/dpr_port_host.sv
// host controller for one port of an asynchronous two-port memory with contention and mailbox flags
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
module dpr_port_host (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  // axi4-lite register bus
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [dpr_host_pkg::AXI_AW-1:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [dpr_host_pkg::AXI_DW-1:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [dpr_host_pkg::AXI_AW-1:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [dpr_host_pkg::AXI_DW-1:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // memory port pins
  output logic [dpr_host_pkg::ADDR_W-1:0] O_PORT_ADDR,
  output logic O_PORT_CS_N,
  output logic O_PORT_WE_N,
  output logic O_PORT_OE_N,
  input wire logic [dpr_host_pkg::DATA_W-1:0] I_PORT_DATA,
  output logic [dpr_host_pkg::DATA_W-1:0] O_PORT_DATA,
  output logic O_PORT_DATA_OE,
  // flags from the memory
  input wire logic I_CONTENTION_FLAG_N,
  input wire logic I_MAILBOX_FLAG_N
);
  import dpr_host_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_WPULSE = 5'b00100,
    ST_RWAIT = 5'b01000,
    ST_FINISH = 5'b10000
  } op_state_e;

  op_state_e state_q;
  op_state_e state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic is_write_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [ADDR_W-1:0] pin_addr_q;
  logic [DATA_W-1:0] pin_data_q;
  logic [DATA_W-1:0] rdata_q;
  logic done_q;
  logic stall_q;
  logic wr_en;
  logic [AXI_AW-1:0] wr_addr;
  logic [AXI_DW-1:0] wr_data;
  logic [3:0] wr_strb;
  logic [AXI_AW-1:0] rd_addr;
  logic [AXI_DW-1:0] rd_data;
  logic [AXI_DW-1:0] status_word;

  // register bus front end
  dpr_axil_port u_bus (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_awvalid(I_AWVALID),
    .o_awready(O_AWREADY),
    .i_awaddr(I_AWADDR),
    .i_wvalid(I_WVALID),
    .o_wready(O_WREADY),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .o_bvalid(O_BVALID),
    .i_bready(I_BREADY),
    .o_bresp(O_BRESP),
    .i_arvalid(I_ARVALID),
    .o_arready(O_ARREADY),
    .i_araddr(I_ARADDR),
    .o_rvalid(O_RVALID),
    .i_rready(I_RREADY),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .o_wr_en(wr_en),
    .o_wr_addr(wr_addr),
    .o_wr_data(wr_data),
    .o_wr_strb(wr_strb),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data)
  );

  // register write decode; a start while busy is dropped
  wire idle = (state_q == ST_IDLE);
  wire ctrl_wr = wr_en && reg_hit(wr_addr, REG_CTRL) && wr_strb[0];
  wire start = ctrl_wr && wr_data[CTRL_START_BIT] && idle;
  wire addr_wr = wr_en && reg_hit(wr_addr, REG_ADDR);
  wire wdata_wr = wr_en && reg_hit(wr_addr, REG_WDATA) && wr_strb[0];
  wire status_wr = wr_en && reg_hit(wr_addr, REG_STATUS) && wr_strb[0];
  wire cont_low = !I_CONTENTION_FLAG_N;
  wire op_end = (state_q == ST_FINISH);
  wire read_take = (state_q == ST_RWAIT) && (cnt_q == 4'h0) && !cont_low;

  // status reflects live flags so software can see a pending mailbox without reading memory
  assign status_word = {27'h0, !I_MAILBOX_FLAG_N, cont_low, stall_q, done_q, !idle};
  assign rd_data = reg_hit(rd_addr, REG_CTRL) ? {30'h0, is_write_q, 1'b0} :
                   reg_hit(rd_addr, REG_ADDR) ? {22'h0, addr_q} :
                   reg_hit(rd_addr, REG_WDATA) ? {24'h0, wdata_q} :
                   reg_hit(rd_addr, REG_STATUS) ? status_word :
                   reg_hit(rd_addr, REG_RDATA) ? {24'h0, rdata_q} : 32'h0;

  // software-visible registers; done and stall sets win over a same-cycle clear
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      is_write_q <= 1'b0;
      addr_q <= ADDR_RESET;
      wdata_q <= DATA_RESET;
      done_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      if (ctrl_wr && idle) begin
        is_write_q <= wr_data[CTRL_WRITE_BIT];
      end
      if (addr_wr) begin
        addr_q <= wr_data[ADDR_W-1:0];
      end
      if (wdata_wr) begin
        wdata_q <= wr_data[DATA_W-1:0];
      end
      done_q <= op_end | (done_q & ~(status_wr & wr_data[STAT_DONE_BIT]));
      stall_q <= (!idle & cont_low) | (stall_q & ~(status_wr & wr_data[STAT_STALL_BIT]));
    end
  end

  // pin sequencing: write-pulse and read-wait counts reload while contention is low, so release starts the wait afresh
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_SETUP;
          cnt_d = 4'(FLAG_CYC);
        end
      end
      ST_SETUP: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (is_write_q) begin
          state_d = ST_WPULSE;
          cnt_d = 4'(WPULSE_CYC);
        end else begin
          state_d = ST_RWAIT;
          cnt_d = 4'(READ_CYC);
        end
      end
      ST_WPULSE: begin
        if (cont_low) begin
          cnt_d = 4'(HOLD_CYC);
        end else if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          state_d = ST_FINISH;
        end
      end
      ST_RWAIT: begin
        if (cont_low) begin
          cnt_d = 4'(RELEASE_CYC);
        end else if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          state_d = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // state, pin latches and read capture
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      pin_addr_q <= ADDR_RESET;
      pin_data_q <= DATA_RESET;
      rdata_q <= DATA_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (start) begin
        pin_addr_q <= addr_q;
        pin_data_q <= wdata_q;
      end
      if (read_take) begin
        rdata_q <= I_PORT_DATA;
      end
    end
  end

  // pins: address and data stay latched for the whole access; data is driven only on writes
  assign O_PORT_ADDR = pin_addr_q;
  assign O_PORT_DATA = pin_data_q;
  assign O_PORT_CS_N = !(state_q inside {ST_SETUP, ST_WPULSE, ST_RWAIT});
  assign O_PORT_WE_N = (state_q != ST_WPULSE);
  assign O_PORT_OE_N = (state_q != ST_RWAIT);
  assign O_PORT_DATA_OE = is_write_q && (state_q inside {ST_SETUP, ST_WPULSE});

  // helper ages: cycles since select fell and since contention was last seen low
  logic [3:0] cs_age_q;
  logic [3:0] free_age_q;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      cs_age_q <= 4'h0;
      free_age_q <= 4'h0;
    end else begin
      cs_age_q <= O_PORT_CS_N ? 4'h0 : ((cs_age_q == 4'hf) ? cs_age_q : cs_age_q + 4'h1);
      free_age_q <= cont_low ? 4'h0 : ((free_age_q == 4'hf) ? free_age_q : free_age_q + 4'h1);
    end
  end

  a_strobe_after_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    $fell(O_PORT_WE_N) |-> !O_PORT_CS_N && cs_age_q >= 4'(FLAG_CYC))
    else $error("write strobe fell before contention flag could settle");

  a_hold_after_release: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    $rose(O_PORT_WE_N) |-> $past(free_age_q) >= 4'(HOLD_CYC))
    else $error("write strobe released too soon after contention ended");

  a_strobe_held_stall: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    !O_PORT_WE_N && cont_low |=> !O_PORT_WE_N)
    else $error("write strobe dropped while contention flag was low");

  a_read_after_release: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    read_take |-> free_age_q >= 4'(RELEASE_CYC) && !O_PORT_OE_N)
    else $error("read data taken before release-to-data delay");

  a_read_access_time: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    $fell(O_PORT_OE_N) |-> !read_take [*2])
    else $error("read data taken before access time");

  a_no_bus_fight: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    O_PORT_DATA_OE |-> O_PORT_OE_N)
    else $error("data driven while memory output enabled");

  a_done_follows: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
    start ##1 (!cont_low) [*8] |-> ##[1:4] done_q)
    else $error("uncontended access did not finish in time");

endmodule : dpr_port_host

// File: test/dpr_mem_model.sv
// behavioural model of one memory port with its contention input and mailbox flag
module dpr_mem_model #(
  // set for a slave part, whose contention input skips the release-to-data wait
  parameter bit SLAVE = 1'b0
) (
  // clock
  input wire logic i_clk,
  // port pins
  input wire logic [dpr_host_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_cs_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic [dpr_host_pkg::DATA_W-1:0] i_data,
  input wire logic i_data_oe,
  output logic [dpr_host_pkg::DATA_W-1:0] o_data,
  // flags
  input wire logic i_busy_n,
  input wire logic i_far_set,
  output logic o_mbox_n,
  output logic o_far_mbox_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import dpr_host_pkg::*;
  logic [7:0] mem [1024];
  logic [7:0] last_q, wd_q;
  logic [9:0] wa_q;
  logic wr_q;
  int hold_q, rel_q;
  wire drive = !i_cs_n && i_we_n && !i_oe_n;
  wire valid = SLAVE || rel_q >= RELEASE_CYC;
  wire wr = !i_cs_n && !i_we_n;
  // released pins show the inverse of the last value so a stale sample is caught
  assign o_data = drive ? (valid ? mem[i_addr] : ~mem[i_addr]) : ~last_q;
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'(i);
    last_q = 8'h00;
    wr_q = 1'h0;
    hold_q = 0;
    rel_q = 8;
    o_mbox_n = 1'h1;
    o_far_mbox_n = 1'h1;
  end
  // a write lands at strobe end only if it was unblocked for the hold interval
  always @(posedge i_clk) begin
    wr_q <= wr;
    wa_q <= i_addr;
    wd_q <= i_data_oe ? i_data : ~i_data;
    hold_q <= !i_busy_n ? 0 : (wr ? hold_q + 1 : 0);
    rel_q <= !i_busy_n ? 0 : (rel_q < 8 ? rel_q + 1 : rel_q);
    if (drive) last_q <= o_data;
    if (wr_q && !wr && hold_q >= HOLD_CYC) mem[wa_q] <= wd_q;
    // far flag only ever falls here: the far host's clearing access is not modelled
    if (wr_q && !wr && hold_q >= HOLD_CYC && wa_q == MBOX_RIGHT_ADDR) o_far_mbox_n <= 1'h0;
    if (i_far_set) o_mbox_n <= 1'h0;
    else if (!i_cs_n && !i_oe_n && i_busy_n && i_addr == MBOX_LEFT_ADDR) o_mbox_n <= 1'h1;
  end
endmodule : dpr_mem_model

// File: test/dual_port_ram_mailbox_arbiter_test.sv
// self-checking bench for the port host with a memory model on its pins
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module dual_port_ram_mailbox_arbiter_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dpr_host_pkg::*;
  int fail_count = 0, n_tests = 0, seed = 32'h120a;
  logic clk = 1'h0, rst = 1'h1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, busy_n = 1, far_set = 0;
  logic [7:0] awaddr = 0, araddr = 0, pdin, pdout;
  logic [31:0] wdata = 0, rdata, s;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, cs_n, we_n, oe_n, pdoe, mbox_n, far_mbox_n;
  logic [1:0] bresp, rresp;
  logic [9:0] paddr, a;
  logic [7:0] d, q;
  always #12.5 clk = ~clk;
  dpr_port_host dut_u (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_AWADDR(awaddr), .I_WVALID(wvalid), .O_WREADY(wready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .O_BVALID(bvalid), .I_BREADY(bready), .O_BRESP(bresp), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .I_ARADDR(araddr), .O_RVALID(rvalid), .I_RREADY(rready), .O_RDATA(rdata), .O_RRESP(rresp),
    .O_PORT_ADDR(paddr), .O_PORT_CS_N(cs_n), .O_PORT_WE_N(we_n), .O_PORT_OE_N(oe_n), .I_PORT_DATA(pdin),
    .O_PORT_DATA(pdout), .O_PORT_DATA_OE(pdoe), .I_CONTENTION_FLAG_N(busy_n), .I_MAILBOX_FLAG_N(mbox_n));
  dpr_mem_model mem_u (.i_clk(clk), .i_addr(paddr), .i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n),
    .i_data(pdout), .i_data_oe(pdoe), .o_data(pdin), .i_busy_n(busy_n), .i_far_set(far_set), .o_mbox_n(mbox_n),
    .o_far_mbox_n(far_mbox_n));
  // status word expected once an access has completed
  function automatic logic [31:0] exp_stat(input logic mb, input logic st);
    exp_stat = 32'h0;
    exp_stat[STAT_DONE_BIT] = 1'h1;
    exp_stat[STAT_STALL_BIT] = st;
    exp_stat[STAT_MBOX_BIT] = mb;
  endfunction : exp_stat
  // bus write: both channels offered together, each dropped at its own handshake
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt);
    logic awr, wr, awd, wd;
    @(posedge clk);
    awd = 0;
    wd = 0;
    awvalid <= 1;
    awaddr <= ad;
    wvalid <= 1;
    wdata <= dt;
    bready <= 1;
    while (!(awd && wd)) begin
      @(negedge clk);
      awr = awready;
      wr = wready;
      @(posedge clk);
      if (awr && !awd) begin awd = 1; awvalid <= 0; end
      if (wr && !wd) begin wd = 1; wvalid <= 0; end
    end
    do begin @(negedge clk); awr = bvalid; if (awr) `CHK(bresp, RESP_OKAY) @(posedge clk); end while (!awr);
    bready <= 0;
  endtask : axw
  // bus read: ready is sampled before the edge that completes the handshake
  task automatic axr(input logic [7:0] ad, output logic [31:0] dt);
    logic r;
    @(posedge clk);
    arvalid <= 1;
    araddr <= ad;
    rready <= 1;
    do begin @(negedge clk); r = arready; @(posedge clk); end while (!r);
    arvalid <= 0;
    do begin @(negedge clk); r = rvalid; dt = rdata; if (r) `CHK(rresp, RESP_OKAY) @(posedge clk); end while (!r);
    rready <= 0;
  endtask : axr
  // one memory access through the registers; returns read byte and final status
  task automatic op(input logic w, input logic [9:0] ad, input logic [7:0] dt, output logic [7:0] rq,
                    output logic [31:0] st);
    int n;
    axw(REG_ADDR, {22'h0, ad});
    axw(REG_WDATA, {24'h0, dt});
    axw(REG_CTRL, {30'h0, w, 1'h1});
    n = 0;
    do begin axr(REG_STATUS, st); n++; end while (!st[STAT_DONE_BIT] && n < 50);
    axw(REG_STATUS, 32'h6);
    axr(REG_RDATA, s);
    rq = s[7:0];
  endtask : op
  // the far port wins arbitration once this port selects, for k cycles
  task automatic stall(input int k);
    do @(negedge clk); while (cs_n);
    @(posedge clk);
    busy_n <= 0;
    repeat (k) @(posedge clk);
    busy_n <= 1;
  endtask : stall
  task automatic test_done;
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // hang guard sized well above the expected run of a few hundred cycles
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    axr(REG_STATUS, s);
    `CHK(s, 32'h0)
    axr(REG_ADDR, s);
    `CHK(s, {22'h0, ADDR_RESET})
    axw(8'h1c, 32'hffff_ffff);
    axr(8'h1c, s);
    `CHK(s, 32'h0)
    // a data write without its low byte lane is dropped
    wstrb <= 4'he;
    axw(REG_WDATA, 32'h5a);
    wstrb <= 4'hf;
    axr(REG_WDATA, s);
    `CHK(s, 32'h0)
    // live contention shows in status while idle, without marking a stall
    busy_n <= 1'h0;
    axr(REG_STATUS, s);
    `CHK(s, 32'h8)
    busy_n <= 1'h1;
    @(negedge clk);
    `CHK({cs_n, pdoe}, 2'h2)
    // boundary addresses first, then random ones
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 10'h000 : (i == 1) ? 10'h3fd : 10'($random(seed)) & 10'h1ff;
      d = 8'($random(seed));
      op(1, a, d, q, s);
      `CHK(s, exp_stat(0, 0))
      @(negedge clk);
      `CHK({cs_n, we_n, pdoe}, 3'h6)
      op(0, a, 8'h00, q, s);
      `CHK(q, d)
    end
    // contention from setup into the write pulse, which is held until the hold time after release
    fork op(1, 10'h155, 8'ha5, q, s); stall(4); join
    `CHK(s, exp_stat(0, 1))
    // control reads back the write direction, start reads as zero
    axr(REG_CTRL, s);
    `CHK(s, 32'h2)
    op(0, 10'h155, 8'h00, q, s);
    `CHK(q, 8'ha5)
    // contention during a read: data is garbage until the release delay runs out
    fork op(0, 10'h155, 8'h00, q, s); stall(5); join
    `CHK(q, 8'ha5)
    `CHK(s, exp_stat(0, 1))
    // a write to the far mailbox raises the far port's flag
    `CHK(far_mbox_n, 1'h1)
    op(1, MBOX_RIGHT_ADDR, 8'hc3, q, s);
    `CHK(far_mbox_n, 1'h0)
    // mailbox byte is user data; flag stays until this port reads it
    op(1, MBOX_LEFT_ADDR, 8'h3c, q, s);
    @(posedge clk);
    far_set <= 1;
    @(posedge clk);
    far_set <= 0;
    axr(REG_STATUS, s);
    `CHK(s[STAT_MBOX_BIT], 1'h1)
    op(1, 10'h020, 8'h11, q, s);
    `CHK(s, exp_stat(1, 0))
    op(0, MBOX_LEFT_ADDR, 8'h00, q, s);
    `CHK(q, 8'h3c)
    axr(REG_STATUS, s);
    `CHK(s[STAT_MBOX_BIT], 1'h0)
    test_done;
  end
endmodule : dual_port_ram_mailbox_arbiter_test
